// ==== logic/evrt_pkg.sv ====
// event link router: register map, field positions, reset values, sizes
// assumes a 32-bit apb slave with byte addresses on paddr[7:0]
package evrt_pkg;

    localparam int NLINK = 30;
    localparam int NEV_IN = 64;
    localparam int NGRP = 2;
    localparam int NPLINK = 4;
    localparam int NPBIT = 8;
    localparam int NIRQ = 3;
    localparam int AW = 8;

    // event counts per variant
    localparam logic [7:0] NEV_LARGE = 8'h3f;
    localparam logic [7:0] NEV_SMALL = 8'h30;
    localparam logic [7:0] EV_NONE = 8'h00;

    // byte addresses
    localparam logic [AW-1:0] A_LINK_BASE = 8'h00;
    localparam logic [AW-1:0] A_LINK_LAST = 8'h74;
    localparam logic [AW-1:0] A_OPT = 8'h80;
    localparam logic [AW-1:0] A_GSET0 = 8'h84;
    localparam logic [AW-1:0] A_GSET1 = 8'h88;
    localparam logic [AW-1:0] A_GCTL0 = 8'h8c;
    localparam logic [AW-1:0] A_GCTL1 = 8'h90;
    localparam logic [AW-1:0] A_GBUF0 = 8'h94;
    localparam logic [AW-1:0] A_GBUF1 = 8'h98;
    localparam logic [AW-1:0] A_PLINK_BASE = 8'ha0;
    localparam logic [AW-1:0] A_PLINK_LAST = 8'hac;
    localparam logic [AW-1:0] A_STOP = 8'hb0;
    localparam logic [AW-1:0] A_TMROP = 8'hb4;
    localparam logic [AW-1:0] A_STAT = 8'hb8;
    localparam logic [AW-1:0] A_MASK = 8'hbc;

    // option control: low power timer route field
    localparam int LPT_LSB = 4;
    localparam logic [1:0] LPT_TO_IRQ = 2'h0;
    localparam logic [1:0] LPT_OFF = 2'h3;
    localparam logic [1:0] LPT_RST = 2'h3;

    // port link register fields
    localparam int PSP_LSB = 3;
    localparam int PBIT_LSB = 0;
    localparam logic [1:0] PSP_OFF = 2'h0;
    localparam logic [1:0] PSP_PORT_B = 2'h1;
    localparam logic [1:0] PSP_PORT_E = 2'h2;

    // group control edge select, bits 1:0
    localparam logic [1:0] EDGE_RISE = 2'h0;
    localparam logic [1:0] EDGE_FALL = 2'h1;

    // status bits
    localparam int ST_LPT = 0;
    localparam int ST_GRP0 = 1;
    localparam int ST_GRP1 = 2;

endpackage

// ==== logic/evrt_router.sv ====
// event link router: routes peripheral events to destinations, port
// event linking for port b / port e, low power timer irq route, apb slave
// assumes event inputs are one-cycle pulses on pclk; port pins are async
// Functional notes
// RQ1: any of 48 (small) or 63 (large) events routes straight to a destination.
// RQ2: software picks which timer operation an incoming event triggers.
// RQ3: port event linking on port b; port e too in the large variant.
// RQ4: single-port mode links exactly one chosen port bit.
// RQ5: group mode links several masked bits of an eight-bit port group.
// RQ6: module stop halts all routing to save power.
// RQ7: link registers exist only at the listed destination indices.
// RQ8: timer route 00 sends compare event as irq, 11 disables it.
// RQ9: small variant routes low power timer compare match 0.
// RQ10: port number 00 disables the port link; 11 is forbidden.
// RQ11: port number 01 picks port b, group one.
// RQ12: port number 10 picks port e, group two, large variant only.
// RQ13: large variant has two port groups, small variant only group one.
// RQ14: four port link registers in large variant, two in small.
// RQ15: each link register holds an eight-bit source event number.
// RQ16: selected source pulse gives one-cycle destination pulse; bad numbers none.
`timescale 1ns/1ps
`default_nettype none

module evrt_router
    import evrt_pkg::*;
#(
    parameter bit LARGE = 1'b1
)
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [evrt_pkg::AW-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [evrt_pkg::NEV_IN-1:0] event_in,
    output logic [evrt_pkg::NLINK-1:0] dest_evt,
    output logic [7:0] timer_op,
    input wire logic lpt_cmp0,
    input wire logic lpt_cmp1,
    output logic lpt_irq,
    input wire logic [evrt_pkg::NPBIT-1:0] port_b_pin,
    input wire logic [evrt_pkg::NPBIT-1:0] port_e_pin,
    output logic [evrt_pkg::NGRP-1:0] grp_evt,
    output logic [evrt_pkg::NPLINK-1:0] single_evt,
    output logic irq
);
    import evrt_pkg::*;

    typedef struct packed {
        logic [NLINK-1:0][7:0] link_sel;
        logic [1:0] lpt_route;
        logic [NGRP-1:0][7:0] grp_set;
        logic [NGRP-1:0][7:0] grp_ctl;
        logic [NGRP-1:0][7:0] grp_buf;
        logic [NPLINK-1:0][7:0] port_link;
        logic stop;
        logic [7:0] tmr_op;
        logic [NIRQ-1:0] stat;
        logic [NIRQ-1:0] mask;
        logic [NGRP-1:0][NPBIT-1:0] pin_s1;
        logic [NGRP-1:0][NPBIT-1:0] pin_s2;
        logic [NGRP-1:0][NPBIT-1:0] pin_prev;
        logic [NLINK-1:0] dest_evt;
        logic [NGRP-1:0] grp_evt;
        logic [NPLINK-1:0] single_evt;
        logic lpt_irq;
        logic [31:0] rdata;
        logic slverr;
    } evrt_state_s;

    evrt_state_s state_q;
    evrt_state_s state_d;

    // destination index has a link register in this variant
    function automatic logic link_ok(input int n);
        logic r;
        r = 1'b0;
        case (n)
            1, 2, 3, 4, 7, 8, 10, 12, 14, 15, 16, 18: r = 1'b1;
            20, 22, 24, 25: r = 1'b1;
            19, 21, 23, 26, 27, 28, 29: r = LARGE;
            default: r = 1'b0;
        endcase
        return r;
    endfunction

    // source number names an existing event
    function automatic logic ev_ok(input logic [7:0] sel);
        return (sel != EV_NONE) && (sel <= (LARGE ? NEV_LARGE : NEV_SMALL));
    endfunction

    // group index exists in this variant
    function automatic logic grp_ok(input int g);
        return (g == 0) || LARGE;
    endfunction

    // port link register index exists in this variant
    function automatic logic plink_ok(input int m);
        return (m < 2) || LARGE;
    endfunction

    // edges of a synchronised port per group edge mode
    function automatic logic [NPBIT-1:0] edges(
        input logic [NPBIT-1:0] cur,
        input logic [NPBIT-1:0] prev,
        input logic [1:0] mode
    );
        logic [NPBIT-1:0] r;
        r = '0;
        unique case (mode)
            EDGE_RISE: r = cur & ~prev;
            EDGE_FALL: r = ~cur & prev;
            default: r = cur ^ prev;
        endcase
        return r;
    endfunction

    // address decode
    function automatic logic mapped(input logic [AW-1:0] a);
        logic r;
        r = 1'b0;
        if (a[1:0] != 2'h0)
            r = 1'b0;
        else if (a <= A_LINK_LAST)
            r = link_ok(int'(a[AW-1:2]));
        else if (a >= A_PLINK_BASE && a <= A_PLINK_LAST)
            r = plink_ok(int'(a[3:2]));
        else
        begin
            unique case (a)
                A_OPT, A_GSET0, A_GCTL0, A_GBUF0: r = 1'b1;
                A_GSET1, A_GCTL1, A_GBUF1: r = LARGE;
                A_STOP, A_TMROP, A_STAT, A_MASK: r = 1'b1;
                default: r = 1'b0;
            endcase
        end
        return r;
    endfunction

    // read value of a mapped address, zero elsewhere
    function automatic logic [31:0] rd_val(
        input evrt_state_s s,
        input logic [AW-1:0] a
    );
        logic [31:0] r;
        r = '0;
        if (!mapped(a))
            r = '0;
        else if (a <= A_LINK_LAST)
            r[7:0] = s.link_sel[a[6:2]];
        else if (a >= A_PLINK_BASE)
        begin
            unique case (a)
                A_STOP: r[0] = s.stop;
                A_TMROP: r[7:0] = s.tmr_op;
                A_STAT: r[NIRQ-1:0] = s.stat;
                A_MASK: r[NIRQ-1:0] = s.mask;
                default: r[7:0] = s.port_link[a[3:2]];
            endcase
        end
        else
        begin
            unique case (a)
                A_OPT: r[LPT_LSB+:2] = s.lpt_route;
                A_GSET0: r[7:0] = s.grp_set[0];
                A_GSET1: r[7:0] = s.grp_set[1];
                A_GCTL0: r[7:0] = s.grp_ctl[0];
                A_GCTL1: r[7:0] = s.grp_ctl[1];
                A_GBUF0: r[7:0] = s.grp_buf[0];
                default: r[7:0] = s.grp_buf[1];
            endcase
        end
        return r;
    endfunction

    always_comb
    begin
        logic setup;
        logic wr;
        logic rclr;
        logic [NGRP-1:0][NPBIT-1:0] edg;
        logic [1:0] psp;
        logic [NIRQ-1:0] set;
        state_d = state_q;
        setup = psel && !penable;
        wr = psel && penable && pwrite && mapped(paddr);
        rclr = psel && penable && !pwrite && (paddr == A_STAT);
        edg = '0;
        psp = PSP_OFF;
        set = '0;

        // apb: read data and error captured in setup, used in access
        if (setup)
        begin
            state_d.rdata = pwrite ? 32'h0 : rd_val(state_q, paddr);
            state_d.slverr = !mapped(paddr);
        end

        // register writes on the access edge
        if (wr)
        begin
            if (paddr <= A_LINK_LAST)
                state_d.link_sel[paddr[6:2]] = pwdata[7:0]; // [RQ7] [RQ15]
            else if (paddr >= A_PLINK_BASE && paddr <= A_PLINK_LAST)
                state_d.port_link[paddr[3:2]] = pwdata[7:0]; // [RQ14]
            else
            begin
                unique case (paddr)
                    A_OPT: state_d.lpt_route = pwdata[LPT_LSB+:2];
                    A_GSET0: state_d.grp_set[0] = pwdata[7:0];
                    A_GSET1: state_d.grp_set[1] = pwdata[7:0]; // [RQ13]
                    A_GCTL0: state_d.grp_ctl[0] = pwdata[7:0];
                    A_GCTL1: state_d.grp_ctl[1] = pwdata[7:0];
                    A_GBUF0: state_d.grp_buf[0] = pwdata[7:0];
                    A_GBUF1: state_d.grp_buf[1] = pwdata[7:0];
                    A_STOP: state_d.stop = pwdata[0]; // [RQ6]
                    A_TMROP: state_d.tmr_op = pwdata[7:0]; // [RQ2]
                    A_MASK: state_d.mask = pwdata[NIRQ-1:0];
                    default: state_d.stat = state_q.stat;
                endcase
            end
        end

        // port pin synchronisers
        state_d.pin_s1[0] = port_b_pin;
        state_d.pin_s1[1] = port_e_pin; // [RQ3]
        state_d.pin_s2 = state_q.pin_s1;
        state_d.pin_prev = state_q.pin_s2;

        // event forwarding to destinations
        for (int i = 0; i < NLINK; i++)
        begin
            state_d.dest_evt[i] = !state_q.stop && link_ok(i)
                && ev_ok(state_q.link_sel[i])
                && event_in[state_q.link_sel[i][5:0]]; // [RQ1] [RQ16]
        end

        // group mode: masked edges give a group event and latch the port
        for (int g = 0; g < NGRP; g++)
        begin
            edg[g] = edges(state_q.pin_s2[g], state_q.pin_prev[g],
                state_q.grp_ctl[g][1:0]);
            state_d.grp_evt[g] = !state_q.stop && grp_ok(g)
                && ((edg[g] & state_q.grp_set[g]) != '0); // [RQ5] [RQ13]
            if (state_d.grp_evt[g])
                state_d.grp_buf[g] = state_q.pin_s2[g];
        end

        // single port mode: one bit of port b or port e
        for (int m = 0; m < NPLINK; m++)
        begin
            psp = state_q.port_link[m][PSP_LSB+:2];
            state_d.single_evt[m] = 1'b0; // [RQ10]
            if (!state_q.stop && plink_ok(m))
            begin
                if (psp == PSP_PORT_B) // [RQ11]
                    state_d.single_evt[m] =
                        edg[0][state_q.port_link[m][PBIT_LSB+:3]]; // [RQ4]
                else if (psp == PSP_PORT_E && LARGE) // [RQ12]
                    state_d.single_evt[m] =
                        edg[1][state_q.port_link[m][PBIT_LSB+:3]];
            end
        end

        // low power timer compare match 0 to the interrupt controller
        state_d.lpt_irq = !state_q.stop && lpt_cmp0
            && (state_q.lpt_route == LPT_TO_IRQ); // [RQ8] [RQ9]

        // sticky status, read clears only what was returned, set wins
        set[ST_LPT] = state_d.lpt_irq;
        set[ST_GRP0] = state_d.grp_evt[0];
        set[ST_GRP1] = state_d.grp_evt[1];
        if (rclr)
            state_d.stat = state_q.stat & ~state_q.rdata[NIRQ-1:0];
        state_d.stat = state_d.stat | set;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            state_q <= '0;
            state_q.lpt_route <= LPT_RST;
        end
        else
        begin
            state_q <= state_d;
        end
    end

    assign prdata = state_q.rdata;
    assign pready = 1'b1;
    assign pslverr = state_q.slverr;
    assign dest_evt = state_q.dest_evt;
    assign timer_op = state_q.tmr_op;
    assign lpt_irq = state_q.lpt_irq;
    assign grp_evt = state_q.grp_evt;
    assign single_evt = state_q.single_evt;
    assign irq = |(state_q.stat & state_q.mask);

    // unused here: second compare match is not routed
    logic unused_cmp1;
    assign unused_cmp1 = lpt_cmp1;

    property p_fwd;
        @(posedge pclk) disable iff (!presetn)
        (!state_q.stop && ev_ok(state_q.link_sel[1])
            && event_in[state_q.link_sel[1][5:0]]) |=> dest_evt[1];
    endproperty
    a_fwd: assert property (p_fwd) // [RQ16]
        else $error("selected event not forwarded");

    property p_fwd_none;
        @(posedge pclk) disable iff (!presetn)
        !ev_ok(state_q.link_sel[2]) |=> !dest_evt[2];
    endproperty
    a_fwd_none: assert property (p_fwd_none) // [RQ16]
        else $error("invalid source number forwarded an event");

    property p_no_link;
        @(posedge pclk) disable iff (!presetn)
        !dest_evt[0] && !dest_evt[5] && !dest_evt[6] && !dest_evt[9];
    endproperty
    a_no_link: assert property (p_no_link) // [RQ7]
        else $error("event on a destination without link register");

    property p_lpt_irq;
        @(posedge pclk) disable iff (!presetn)
        (!state_q.stop && lpt_cmp0 && state_q.lpt_route == LPT_TO_IRQ)
            |=> lpt_irq ##1 state_q.stat[ST_LPT];
    endproperty
    a_lpt_irq: assert property (p_lpt_irq) // [RQ8]
        else $error("timer compare not routed as irq");

    property p_lpt_off;
        @(posedge pclk) disable iff (!presetn)
        (state_q.lpt_route == LPT_OFF)[*2] |-> !lpt_irq;
    endproperty
    a_lpt_off: assert property (p_lpt_off) // [RQ8]
        else $error("timer event output while disabled");

    property p_stop;
        @(posedge pclk) disable iff (!presetn)
        state_q.stop |=> (dest_evt == '0) && (grp_evt == '0)
            && (single_evt == '0) && !lpt_irq;
    endproperty
    a_stop: assert property (p_stop) // [RQ6]
        else $error("activity during module stop");

    property p_psp_off;
        @(posedge pclk) disable iff (!presetn)
        (state_q.port_link[0][PSP_LSB+:2] == PSP_OFF) |=> !single_evt[0];
    endproperty
    a_psp_off: assert property (p_psp_off) // [RQ10]
        else $error("disabled port link produced an event");

    property p_small_grp;
        @(posedge pclk) disable iff (!presetn)
        !LARGE |-> (grp_evt[1] == 1'b0) && (single_evt[3:2] == 2'b00);
    endproperty
    a_small_grp: assert property (p_small_grp) // [RQ13]
        else $error("small variant used group two or port links 2..3");

    property p_single;
        @(posedge pclk) disable iff (!presetn)
        (!state_q.stop && state_q.port_link[0][PSP_LSB+:2] == PSP_PORT_B
            && state_q.grp_ctl[0][1:0] == EDGE_RISE
            && state_q.pin_s2[0][state_q.port_link[0][2:0]]
            && !state_q.pin_prev[0][state_q.port_link[0][2:0]])
            |=> single_evt[0];
    endproperty
    a_single: assert property (p_single) // [RQ4]
        else $error("single port edge not linked");

    property p_group;
        @(posedge pclk) disable iff (!presetn)
        (!state_q.stop && state_q.grp_ctl[0][1:0] == EDGE_RISE
            && ((state_q.pin_s2[0] & ~state_q.pin_prev[0]
                & state_q.grp_set[0]) != '0))
            |=> grp_evt[0] && (state_q.grp_buf[0] == $past(state_q.pin_s2[0]));
    endproperty
    a_group: assert property (p_group) // [RQ5]
        else $error("group edge not linked or buffer not latched");

endmodule

`default_nettype wire

// ==== tb/evrt_periph_model.sv ====
// far side model: event sources, timer compare, port pins, pulse sinks
// assumes one pclk domain; counts every destination cycle seen high
`timescale 1ns/1ps
`default_nettype none

module evrt_periph_model
    import evrt_pkg::*;
(
    input wire logic pclk,
    input wire logic [evrt_pkg::NLINK-1:0] dest_evt,
    input wire logic lpt_irq,
    input wire logic [evrt_pkg::NGRP-1:0] grp_evt,
    input wire logic [evrt_pkg::NPLINK-1:0] single_evt,
    output logic [evrt_pkg::NEV_IN-1:0] event_in,
    output logic lpt_cmp0,
    output logic lpt_cmp1,
    output logic [evrt_pkg::NPBIT-1:0] port_b_pin,
    output logic [evrt_pkg::NPBIT-1:0] port_e_pin
);
    import evrt_pkg::*;
    int dest_cnt [NLINK];
    int lpt_cnt;
    int grp_cnt [NGRP];
    int single_cnt [NPLINK];
    logic clr_q = 1'b0;

    initial
    begin
        event_in = '0;
        lpt_cmp0 = 1'b0;
        lpt_cmp1 = 1'b0;
        port_b_pin = '0;
        port_e_pin = '0;
    end

    // one count per cycle high, so a stretched pulse shows as extra
    always @(posedge pclk)
    begin
        lpt_cnt <= clr_q ? 0 : lpt_cnt + int'(lpt_irq);
        foreach (dest_cnt[i])
            dest_cnt[i] <= clr_q ? 0 : dest_cnt[i] + int'(dest_evt[i]);
        foreach (grp_cnt[i])
            grp_cnt[i] <= clr_q ? 0 : grp_cnt[i] + int'(grp_evt[i]);
        foreach (single_cnt[i])
            single_cnt[i] <= clr_q ? 0 : single_cnt[i] + int'(single_evt[i]);
    end

    task automatic clr();
        @(posedge pclk);
        clr_q <= 1'b1;
        @(posedge pclk);
        clr_q <= 1'b0;
    endtask

    // single-cycle source pulse
    task automatic fire(input int k);
        @(posedge pclk);
        event_in[k] <= 1'b1;
        @(posedge pclk);
        event_in[k] <= 1'b0;
    endtask

    task automatic cmp0();
        @(posedge pclk);
        lpt_cmp0 <= 1'b1;
        @(posedge pclk);
        lpt_cmp0 <= 1'b0;
    endtask

    task automatic cmp1();
        @(posedge pclk);
        lpt_cmp1 <= 1'b1;
        @(posedge pclk);
        lpt_cmp1 <= 1'b0;
    endtask

    task automatic pins(input logic [7:0] b, input logic [7:0] e);
        @(posedge pclk);
        port_b_pin <= b;
        port_e_pin <= e;
    endtask
endmodule

`default_nettype wire

// ==== tb/test_event_link_router.sv ====
// testbench for the event link router, large variant, apb register access
// assumes evrt_pkg map and the peripheral model on the far side
`timescale 1ns/1ps
`default_nettype none

module test_event_link_router;
    import evrt_pkg::*;
    logic pclk = 1'b0;
    logic presetn;
    logic psel;
    logic penable;
    logic pwrite;
    logic [AW-1:0] paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic [NEV_IN-1:0] event_in;
    logic [NLINK-1:0] dest_evt;
    logic [7:0] timer_op;
    logic lpt_cmp0;
    logic lpt_cmp1;
    logic lpt_irq;
    logic [NPBIT-1:0] port_b_pin;
    logic [NPBIT-1:0] port_e_pin;
    logic [NGRP-1:0] grp_evt;
    logic [NPLINK-1:0] single_evt;
    logic irq;
    logic [31:0] rd;
    logic err;
    int fails = 0;
    int cmp_count = 0;

    always #12.5 pclk = ~pclk;

    evrt_router #(.LARGE(1'b1)) dut (.pclk(pclk), .presetn(presetn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .event_in(event_in), .dest_evt(dest_evt),
        .timer_op(timer_op), .lpt_cmp0(lpt_cmp0), .lpt_cmp1(lpt_cmp1),
        .lpt_irq(lpt_irq), .port_b_pin(port_b_pin),
        .port_e_pin(port_e_pin), .grp_evt(grp_evt),
        .single_evt(single_evt), .irq(irq));

    evrt_periph_model per (.pclk(pclk), .dest_evt(dest_evt),
        .lpt_irq(lpt_irq), .grp_evt(grp_evt), .single_evt(single_evt),
        .event_in(event_in), .lpt_cmp0(lpt_cmp0), .lpt_cmp1(lpt_cmp1),
        .port_b_pin(port_b_pin), .port_e_pin(port_e_pin));

    task automatic tally_and_finish();
        $display("mismatches %0d comparisons %0d", fails, cmp_count);
        if (fails == 0 && cmp_count > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            fails++;
            $display("wrong value at %0t got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic apb(input logic w, input logic [7:0] a, input int d);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= 32'(d);
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1)
            @(posedge pclk);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic rdc(input logic [7:0] a, input int exp, input logic e);
        apb(1'b0, a, 0);
        check({31'h0, pready}, 32'h1);
        check(rd, 32'(exp));
        check({31'h0, err}, {31'h0, e});
    endtask

    function automatic logic has_link(input int n);
        return n inside {[1:4], 7, 8, 10, 12, [14:16], [18:29]};
    endfunction

    task automatic t_reset();
        rdc(A_OPT, 'h30, 1'b0);
        rdc(A_STAT, 0, 1'b0);
        check({31'h0, irq}, 32'h0);
    endtask

    task automatic t_map();
        // values above 63 name no event, so routing stays quiet
        for (int n = 0; n < NLINK; n++)
            apb(1'b1, 8'(4 * n), 'hc0 + n);
        for (int n = 0; n < NLINK; n++)
            rdc(8'(4 * n), has_link(n) ? 'hc0 + n : 0, !has_link(n));
        rdc(A_PLINK_LAST, 0, 1'b0);
        rdc(A_GBUF1, 0, 1'b0);
        apb(1'b1, 8'h9c, 'h55);
        rdc(8'h9c, 0, 1'b1);
    endtask

    task automatic t_route();
        apb(1'b1, 8'h04, 5);
        apb(1'b1, 8'h0c, 5);
        apb(1'b1, 8'h74, 63);
        apb(1'b1, 8'h08, 0);
        per.clr();
        per.fire(5);
        per.fire(5);
        per.fire(63);
        per.fire(0);
        per.fire(6);
        repeat (3) @(posedge pclk);
        check(32'(per.dest_cnt[1]), 2);
        check(32'(per.dest_cnt[3]), 2);
        check(32'(per.dest_cnt[29]), 1);
        check(32'(per.dest_cnt[2]), 0);
        check(32'(per.dest_cnt[4]), 0);
        apb(1'b1, A_STOP, 1);
        per.fire(5);
        repeat (3) @(posedge pclk);
        check(32'(per.dest_cnt[1]), 2);
        rdc(8'h04, 5, 1'b0);
        apb(1'b1, A_STOP, 0);
    endtask

    task automatic t_timer_op();
        apb(1'b1, A_TMROP, 'ha5);
        @(posedge pclk);
        check({24'h0, timer_op}, 'ha5);
        rdc(A_TMROP, 'ha5, 1'b0);
    endtask

    task automatic t_lpt();
        per.clr();
        per.cmp0();
        repeat (3) @(posedge pclk);
        check(32'(per.lpt_cnt), 0);
        apb(1'b1, A_OPT, 0);
        per.cmp0();
        repeat (3) @(posedge pclk);
        check(32'(per.lpt_cnt), 1);
        per.cmp1();
        repeat (3) @(posedge pclk);
        check(32'(per.lpt_cnt), 1);
        check({31'h0, irq}, 32'h0);
        apb(1'b1, A_MASK, 'h7);
        @(posedge pclk);
        check({31'h0, irq}, 32'h1);
        rdc(A_STAT, 'h1, 1'b0);
        @(posedge pclk);
        check({31'h0, irq}, 32'h0);
        apb(1'b1, A_OPT, 'h30);
    endtask

    task automatic t_ports();
        apb(1'b1, 8'ha0, 'h0b);
        apb(1'b1, 8'ha4, 'h12);
        apb(1'b1, 8'ha8, 'h01);
        apb(1'b1, 8'hac, 'h0d);
        apb(1'b1, A_GSET0, 'h0f);
        apb(1'b1, A_GSET1, 'h04);
        per.clr();
        per.pins(8'h08, 8'h00);
        repeat (8) @(posedge pclk);
        check(32'(per.single_cnt[0]), 1);
        check(32'(per.single_cnt[3]), 0);
        check(32'(per.grp_cnt[0]), 1);
        check(32'(per.grp_cnt[1]), 0);
        rdc(A_GBUF0, 'h08, 1'b0);
        per.pins(8'h2a, 8'h04);
        repeat (8) @(posedge pclk);
        check(32'(per.single_cnt[3]), 1);
        check(32'(per.single_cnt[2]), 0);
        check(32'(per.single_cnt[1]), 1);
        check(32'(per.grp_cnt[0]), 2);
        check(32'(per.grp_cnt[1]), 1);
        check({31'h0, irq}, 32'h1);
        rdc(A_STAT, 'h6, 1'b0);
        apb(1'b1, A_GCTL0, 32'(EDGE_FALL));
        per.pins(8'h00, 8'h04);
        repeat (8) @(posedge pclk);
        check(32'(per.grp_cnt[0]), 3);
        // both edges on group two: a falling pin counts too
        apb(1'b1, A_GCTL1, 'h2);
        per.pins(8'h00, 8'h00);
        repeat (8) @(posedge pclk);
        check(32'(per.grp_cnt[1]), 2);
    endtask

    initial
    begin
        repeat (20000) @(posedge pclk);
        fails++;
        tally_and_finish();
    end

    initial
    begin
        presetn <= 1'b0;
        psel <= 1'b0;
        penable <= 1'b0;
        pwrite <= 1'b0;
        paddr <= '0;
        pwdata <= '0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        t_reset();
        t_map();
        t_route();
        t_timer_op();
        t_lpt();
        t_ports();
        tally_and_finish();
    end
endmodule

`default_nettype wire
